// *** logic/tcg_check.sv ***
// Purpose: legality check of a requested channel 6 setup
// Assumes: inputs are stable host configuration registers
// Notes: purely combinational
`default_nettype none
`include "tcg_defs.svh"

module tcg_check (
    // requested setup
    input wire logic [2:0] mode,
    input wire logic [2:0] clk_sel,
    input wire logic [15:0] cmp,
    // verdict
    output logic ok
);

    function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo,
                                      input logic [15:0] hi);
        in_range = (v >= lo) && (v <= hi);
    endfunction

    logic presc;

    always_comb begin
        presc = (clk_sel <= `TCG_CK_LAST_PRESC);
        case (mode)
            // event counting only from the pin, timing only from prescalers
            `TCG_M_TIMER8: ok = in_range(cmp, 16'h0001, 16'h00ff)
                && (presc || clk_sel == `TCG_CK_PIN);
            `TCG_M_DIV8: ok = in_range(cmp, 16'h0001, 16'h00ff) && presc;
            `TCG_M_PWM8: ok = in_range(cmp, 16'h0002, 16'h00fe)
                && (clk_sel != `TCG_CK_PIN);
            // lower channel has no pin input, so 16-bit counts prescalers only
            `TCG_M_TIMER16: ok = in_range(cmp, 16'h0001, 16'hffff) && presc;
            `TCG_M_DIV16: ok = in_range(cmp, 16'h0001, 16'hffff) && presc;
            `TCG_M_PULSE16: ok = in_range(cmp, 16'h0001, 16'hffff) && presc;
            default: ok = 1'b0;
        endcase
    end

endmodule // tcg_check

`default_nettype wire

// *** logic/tcg_defs.svh ***
// Purpose: constants for the timer channel pair host controller
// Assumes: device registers are reached through a byte wide write port
// Notes: host register map and device side addresses live here
`ifndef TCG_DEFS_SVH
`define TCG_DEFS_SVH

// device side addresses
`define TCG_DEV_CH5_CTRL 8'h1a
`define TCG_DEV_CH6_CTRL 8'h1b
`define TCG_DEV_CMP5 8'h1e
`define TCG_DEV_CMP6 8'h1f
`define TCG_DEV_PORT_LATCH 8'h30
`define TCG_DEV_GATE_SEL 8'h31
`define TCG_DEV_LATCH_SET 8'hff
`define TCG_DEV_GATE_OFF 8'h00

// control register fields
`define TCG_FF_BIT 7
`define TCG_CK_MSB 6
`define TCG_CK_LSB 4
`define TCG_RUN_BIT 3
`define TCG_MODE_MSB 2
`define TCG_MODE_LSB 0
`define TCG_CTRL_RESET 8'h00

// mode and clock codes
`define TCG_M_TIMER8 3'h0
`define TCG_M_DIV8 3'h1
`define TCG_M_PWM8 3'h2
`define TCG_M_CASCADE 3'h3
`define TCG_M_TIMER16 3'h4
`define TCG_M_WARM16 3'h5
`define TCG_M_DIV16 3'h6
`define TCG_M_PULSE16 3'h7
`define TCG_CK_LAST_PRESC 3'h3
`define TCG_CK_PIN 3'h7

// host register map
`define TCG_H_CFG 4'h0
`define TCG_H_CMP 4'h1
`define TCG_H_CMD 4'h2
`define TCG_H_STATUS 4'h3
`define TCG_CMD_START 0
`define TCG_CMD_STOP 1
`define TCG_CMD_LEVEL 2
`define TCG_ST_ERR 2

`endif

// *** logic/tcg_host.sv ***
// Purpose: host that programs and runs timer channel 6 (with 5 as low half)
// Assumes: device takes one byte write per cycle on DEV_ADDR/DEV_WDATA
// Notes: commands arriving while a sequence runs are ignored without error
`default_nettype none
`include "tcg_defs.svh"

module tcg_host (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RST_N,
    // host register port
    input wire logic [3:0] HOST_ADDR,
    input wire logic [15:0] HOST_WDATA,
    input wire logic HOST_WR,
    input wire logic HOST_RD,
    output logic [15:0] HOST_RDATA,
    // device register write port
    output logic [7:0] DEV_ADDR,
    output logic [7:0] DEV_WDATA,
    output logic DEV_WR,
    // device pins
    input wire logic DEV_IRQ_PIN,
    input wire logic DEV_DIV_OUT_PIN
);

    ////////////////////////////////////////////////////////////////////////////
    // host registers

    logic [6:0] cfg_reg;
    logic [6:0] cfg_next;
    logic [15:0] cmp_reg;
    logic [15:0] cmp_next;
    logic err_reg;
    logic err_next;
    logic [7:0] irq_cnt_reg;
    logic [7:0] irq_cnt_next;
    logic irq_lvl_q_reg;
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;
    logic cmd_start;
    logic cmd_stop;
    logic cmd_level;
    logic err_set;
    logic [1:0] pin_lvl;
    logic cfg_ok;
    logic running;
    logic busy;
    tcg_pkg::tcg_byte_t ctrl_reg;

    tcg_sync #(
        .W(2)
    ) u_sync (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .pin({DEV_DIV_OUT_PIN, DEV_IRQ_PIN}),
        .level(pin_lvl)
    );

    tcg_check u_check (
        .mode(cfg_reg[2:0]),
        .clk_sel(cfg_reg[5:3]),
        .cmp(cmp_reg),
        .ok(cfg_ok)
    );

    assign running = ctrl_reg[`TCG_RUN_BIT];

    always_comb begin
        cmd_start = HOST_WR && (HOST_ADDR == `TCG_H_CMD) && HOST_WDATA[`TCG_CMD_START];
        cmd_stop = HOST_WR && (HOST_ADDR == `TCG_H_CMD) && HOST_WDATA[`TCG_CMD_STOP];
        cmd_level = HOST_WR && (HOST_ADDR == `TCG_H_CMD) && HOST_WDATA[`TCG_CMD_LEVEL];
        cfg_next = cfg_reg;
        cmp_next = cmp_reg;
        // config stays frozen while a sequence uses it
        if (HOST_WR && HOST_ADDR == `TCG_H_CFG && !busy) begin
            cfg_next = HOST_WDATA[6:0];
        end
        if (HOST_WR && HOST_ADDR == `TCG_H_CMP && !busy) begin
            cmp_next = HOST_WDATA;
        end
        // a new error beats a clear in the same cycle
        err_next = err_reg;
        if (HOST_WR && HOST_ADDR == `TCG_H_STATUS && HOST_WDATA[`TCG_ST_ERR]) begin
            err_next = 1'b0;
        end
        if (err_set) begin
            err_next = 1'b1;
        end
        irq_cnt_next = irq_cnt_reg;
        if (pin_lvl[0] && !irq_lvl_q_reg) begin
            irq_cnt_next = irq_cnt_reg + 8'h01;
        end
        rdata_next = 16'h0000;
        if (HOST_RD) begin
            case (HOST_ADDR)
                `TCG_H_CFG: rdata_next = {9'h000, cfg_reg};
                `TCG_H_CMP: rdata_next = cmp_reg;
                `TCG_H_STATUS: rdata_next = {irq_cnt_reg, 4'h0, pin_lvl[1], err_reg,
                                             running, busy};
                default: rdata_next = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            cfg_reg <= 7'h00;
            cmp_reg <= 16'h0000;
            err_reg <= 1'b0;
            irq_cnt_reg <= 8'h00;
            irq_lvl_q_reg <= 1'b0;
            rdata_reg <= 16'h0000;
        end else begin
            cfg_reg <= cfg_next;
            cmp_reg <= cmp_next;
            err_reg <= err_next;
            irq_cnt_reg <= irq_cnt_next;
            irq_lvl_q_reg <= pin_lvl[0];
            rdata_reg <= rdata_next;
        end
    end

    assign HOST_RDATA = rdata_reg;

    ////////////////////////////////////////////////////////////////////////////
    // device sequencer

    tcg_pkg::tcg_state_e state_reg;
    tcg_pkg::tcg_state_e state_next;
    logic go_start_reg;
    logic go_start_next;
    logic [6:0] act_reg;
    logic [6:0] act_next;
    logic [15:0] act_cmp_reg;
    logic [15:0] act_cmp_next;
    tcg_pkg::tcg_byte_t ctrl_next;
    logic [7:0] addr_reg;
    logic [7:0] addr_next;
    logic [7:0] wdata_reg;
    logic [7:0] wdata_next;
    logic wr_reg;
    logic wr_next;
    logic wide;
    logic divider;
    logic ff_eff;

    assign busy = (state_reg != tcg_pkg::S_IDLE);
    assign wide = act_reg[2];
    assign divider = (act_reg[2:0] == `TCG_M_DIV8) || (act_reg[2:0] == `TCG_M_DIV16);

    always_comb begin
        state_next = state_reg;
        go_start_next = go_start_reg;
        act_next = act_reg;
        act_cmp_next = act_cmp_reg;
        ctrl_next = ctrl_reg;
        addr_next = 8'h00;
        wdata_next = 8'h00;
        wr_next = 1'b0;
        err_set = 1'b0;
        // timer and event modes keep the flip-flop low
        ff_eff = divider ? act_reg[6] : 1'b0;
        case (state_reg)
            tcg_pkg::S_IDLE: begin
                if (cmd_start) begin
                    if (!cfg_ok) begin
                        err_set = 1'b1;
                    end else begin
                        act_next = cfg_reg;
                        act_cmp_next = cmp_reg;
                        go_start_next = 1'b1;
                        // compare is single stage, so stop before touching it
                        state_next = running ? tcg_pkg::S_STOP_WR
                            : (cfg_reg[2] ? tcg_pkg::S_LO_CTRL : tcg_pkg::S_CMP_HI);
                    end
                end else if (cmd_stop) begin
                    go_start_next = 1'b0;
                    state_next = tcg_pkg::S_STOP_WR;
                end else if (cmd_level) begin
                    if (running) begin
                        err_set = 1'b1;
                    end else begin
                        act_next = cfg_reg;
                        state_next = tcg_pkg::S_LEVEL_WR;
                    end
                end
            end
            tcg_pkg::S_STOP_WR: begin
                // stop write carries the old fields unchanged
                wr_next = 1'b1;
                addr_next = `TCG_DEV_CH6_CTRL;
                wdata_next = ctrl_reg & ~(8'h01 << `TCG_RUN_BIT);
                ctrl_next = wdata_next;
                if (!go_start_reg) begin
                    state_next = tcg_pkg::S_IDLE;
                end else begin
                    state_next = wide ? tcg_pkg::S_LO_CTRL : tcg_pkg::S_CMP_HI;
                end
            end
            tcg_pkg::S_LO_CTRL: begin
                // lower half picks the clock, its mode marks the cascade
                wr_next = 1'b1;
                addr_next = `TCG_DEV_CH5_CTRL;
                wdata_next = {1'b0, act_reg[5:3], 1'b0, `TCG_M_CASCADE};
                state_next = tcg_pkg::S_CMP_LO;
            end
            tcg_pkg::S_CMP_LO: begin
                wr_next = 1'b1;
                addr_next = `TCG_DEV_CMP5;
                wdata_next = act_cmp_reg[7:0];
                state_next = tcg_pkg::S_CMP_HI;
            end
            tcg_pkg::S_CMP_HI: begin
                // low byte first, high byte right after
                wr_next = 1'b1;
                addr_next = `TCG_DEV_CMP6;
                wdata_next = wide ? act_cmp_reg[15:8] : act_cmp_reg[7:0];
                state_next = divider ? tcg_pkg::S_LATCH : tcg_pkg::S_GATE;
            end
            tcg_pkg::S_LATCH: begin
                wr_next = 1'b1;
                addr_next = `TCG_DEV_PORT_LATCH;
                wdata_next = `TCG_DEV_LATCH_SET;
                state_next = tcg_pkg::S_GATE;
            end
            tcg_pkg::S_GATE: begin
                wr_next = 1'b1;
                addr_next = `TCG_DEV_GATE_SEL;
                wdata_next = `TCG_DEV_GATE_OFF;
                state_next = tcg_pkg::S_START_WR;
            end
            tcg_pkg::S_START_WR: begin
                // new mode and clock fields are allowed only on the starting write
                wr_next = 1'b1;
                addr_next = `TCG_DEV_CH6_CTRL;
                wdata_next = {ff_eff, wide ? 3'h0 : act_reg[5:3], 1'b1,
                              act_reg[2:0]};
                ctrl_next = wdata_next;
                go_start_next = 1'b0;
                state_next = tcg_pkg::S_IDLE;
            end
            tcg_pkg::S_LEVEL_WR: begin
                // pin level change is its own write after the stop
                wr_next = 1'b1;
                addr_next = `TCG_DEV_CH6_CTRL;
                wdata_next = {act_reg[6], ctrl_reg[6:0]};
                ctrl_next = wdata_next;
                state_next = tcg_pkg::S_IDLE;
            end
            default: begin
                state_next = tcg_pkg::S_IDLE;
            end
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            state_reg <= tcg_pkg::S_IDLE;
            go_start_reg <= 1'b0;
            act_reg <= 7'h00;
            act_cmp_reg <= 16'h0000;
            ctrl_reg <= `TCG_CTRL_RESET;
            addr_reg <= 8'h00;
            wdata_reg <= 8'h00;
            wr_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            go_start_reg <= go_start_next;
            act_reg <= act_next;
            act_cmp_reg <= act_cmp_next;
            ctrl_reg <= ctrl_next;
            addr_reg <= addr_next;
            wdata_reg <= wdata_next;
            wr_reg <= wr_next;
        end
    end

    assign DEV_ADDR = addr_reg;
    assign DEV_WDATA = wdata_reg;
    assign DEV_WR = wr_reg;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    logic ctrl_wr;
    logic start_wr;

    assign ctrl_wr = wr_reg && (addr_reg == `TCG_DEV_CH6_CTRL);
    assign start_wr = ctrl_wr && wdata_reg[`TCG_RUN_BIT];

    a_stop_keeps_fields: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        ctrl_wr && !wdata_reg[`TCG_RUN_BIT] && $past(ctrl_reg[`TCG_RUN_BIT])
        |-> {wdata_reg[7:4], wdata_reg[2:0]} == {$past(ctrl_reg[7:4]), $past(ctrl_reg[2:0])})
        else $error("stop write altered channel fields");

    a_lower_cascade: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        wr_reg && addr_reg == `TCG_DEV_CH5_CTRL |-> wdata_reg[2:0] == `TCG_M_CASCADE
        ##1 wr_reg && addr_reg == `TCG_DEV_CMP5)
        else $error("lower channel not set to cascade");

    a_clock_legal: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        start_wr && !wdata_reg[2] && wdata_reg[6:4] != `TCG_CK_PIN
        && wdata_reg[2:0] != `TCG_M_PWM8 |-> wdata_reg[6:4] <= `TCG_CK_LAST_PRESC)
        else $error("illegal clock for timer or divider");

    a_cmp8_range: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        start_wr && wdata_reg[2:0] == `TCG_M_PWM8
        |-> act_cmp_reg >= 16'h0002 && act_cmp_reg <= 16'h00fe)
        else $error("8-bit PWM compare out of range");

    a_cmp16_range: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        start_wr && wdata_reg[2] |-> act_cmp_reg != 16'h0000)
        else $error("16-bit compare is zero");

    a_ff_zero: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        start_wr && (wdata_reg[1:0] == 2'h0) |-> !wdata_reg[`TCG_FF_BIT])
        else $error("flip-flop set in timer mode");

    a_cmp_stopped: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        wr_reg && (addr_reg == `TCG_DEV_CMP5 || addr_reg == `TCG_DEV_CMP6)
        |-> !$past(ctrl_reg[`TCG_RUN_BIT]))
        else $error("compare written while running");

    a_latch_first: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        start_wr && wdata_reg[1:0] == 2'h1
        |-> $past(wr_reg, 2) && $past(addr_reg, 2) == `TCG_DEV_PORT_LATCH)
        else $error("divider started without port latch");

    a_gate_zero: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        wr_reg && addr_reg == `TCG_DEV_GATE_SEL |-> wdata_reg == 8'h00 ##1 start_wr)
        else $error("gate select not cleared before start");

    a_level_after_stop: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        ctrl_wr && !wdata_reg[`TCG_RUN_BIT]
        && wdata_reg[`TCG_FF_BIT] != $past(ctrl_reg[`TCG_FF_BIT])
        |-> !$past(ctrl_reg[`TCG_RUN_BIT]))
        else $error("pin level changed on the stop write");

endmodule // tcg_host

`default_nettype wire

// *** logic/tcg_pkg.sv ***
// Purpose: types for the timer channel pair host controller
// Assumes: nothing beyond the defs header
// Notes: one device write per sequencer state other than S_IDLE
`default_nettype none

package tcg_pkg;

    typedef enum logic [3:0] {
        S_IDLE,
        S_STOP_WR,
        S_LO_CTRL,
        S_CMP_LO,
        S_CMP_HI,
        S_LATCH,
        S_GATE,
        S_START_WR,
        S_LEVEL_WR
    } tcg_state_e;

    typedef logic [7:0] tcg_byte_t;

endpackage

`default_nettype wire

// *** logic/tcg_sync.sv ***
// Purpose: three stage synchroniser with agreement filter for device pins
// Assumes: pins are asynchronous to REF_CLK
// Notes: level moves only when stages two and three agree
`default_nettype none

module tcg_sync #(
    parameter int W = 2
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // pins and filtered levels
    input wire logic [W-1:0] pin,
    output logic [W-1:0] level
);

    genvar g;
    generate
        for (g = 0; g < W; g = g + 1) begin : g_bit
            logic s1_reg;
            logic s2_reg;
            logic s3_reg;
            logic lvl_reg;
            logic lvl_next;
            always_comb begin
                lvl_next = (s2_reg == s3_reg) ? s3_reg : lvl_reg;
            end
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    s1_reg <= 1'b0;
                    s2_reg <= 1'b0;
                    s3_reg <= 1'b0;
                    lvl_reg <= 1'b0;
                end else begin
                    s1_reg <= pin[g];
                    s2_reg <= s1_reg;
                    s3_reg <= s2_reg;
                    lvl_reg <= lvl_next;
                end
            end
            assign level[g] = lvl_reg;
        end
    endgenerate

endmodule // tcg_sync

`default_nettype wire

// *** tb/tb_tcg_host.sv ***
// Purpose: self-checking bench for the timer pair host
// Assumes: device model counts once per cycle, or once per event pin fall with clock select 111
// Notes: device writes are captured and compared in order
`default_nettype none

module tb_tcg_host;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [2:0] m; logic [2:0] ck; logic [15:0] cmp; logic err;} tcg_row_s;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic [3:0] ad = 4'h0;
    logic [15:0] wd = 16'h0000;
    logic [15:0] rdat, st, c0;
    logic [7:0] d_ad, d_wd, ctl;
    logic d_wr, irq, dpin;
    logic [15:0] seen_q[$];
    logic [15:0] exp_q[$];
    int fail_count = 0;
    int checks = 0;
    // mode, clock select, compare -> error bit
    tcg_row_s rows[15] = '{
        '{3'h0, 3'h1, 16'h0014, 1'b0}, '{3'h1, 3'h3, 16'h001e, 1'b0},
        '{3'h2, 3'h4, 16'h00fe, 1'b0}, '{3'h4, 3'h2, 16'h0103, 1'b0},
        '{3'h6, 3'h0, 16'h0040, 1'b0}, '{3'h7, 3'h3, 16'h0100, 1'b0},
        '{3'h0, 3'h7, 16'h0009, 1'b0}, '{3'h3, 3'h0, 16'h000a, 1'b1},
        '{3'h5, 3'h0, 16'h0200, 1'b1}, '{3'h0, 3'h0, 16'h0100, 1'b1},
        '{3'h0, 3'h0, 16'h0000, 1'b1}, '{3'h2, 3'h0, 16'h0001, 1'b1},
        '{3'h2, 3'h0, 16'h00ff, 1'b1}, '{3'h1, 3'h7, 16'h000a, 1'b1},
        '{3'h2, 3'h7, 16'h0064, 1'b1}};
    ////////////////////////////////////////////////////////////
    always #2 ref_clk = ~ref_clk;
    tcg_host tcg_host_inst (.REF_CLK(ref_clk), .RST_N(rst_n), .HOST_ADDR(ad),
        .HOST_WDATA(wd), .HOST_WR(wr_s), .HOST_RD(rd_s), .HOST_RDATA(rdat),
        .DEV_ADDR(d_ad), .DEV_WDATA(d_wd), .DEV_WR(d_wr), .DEV_IRQ_PIN(irq),
        .DEV_DIV_OUT_PIN(dpin));
    tcg_dev_model tcg_dev_model_inst (.clk(ref_clk), .rst_n(rst_n), .dev_addr(d_ad),
        .dev_wdata(d_wd), .dev_wr(d_wr), .irq_pin(irq), .div_pin(dpin));
    always @(posedge ref_clk) if (d_wr === 1'b1) seen_q.push_back({d_ad, d_wd});
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        ad <= a;
        wd <= d;
        wr_s <= 1'b1;
        @(posedge ref_clk);
        wr_s <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        ad <= a;
        rd_s <= 1'b1;
        @(posedge ref_clk);
        rd_s <= 1'b0;
        @(negedge ref_clk);
        d = rdat;
    endtask
    // bounded poll: a stuck busy flag must not hang the run
    task automatic idle();
        int n;
        n = 0;
        st = 16'hffff;
        while (st[0] !== 1'b0 && n < 40) begin
            rd(4'h3, st);
            n++;
        end
        chk(16'(st[0]), 16'h0000, "busy");
    endtask
    task automatic cmpq();
        chk(16'(seen_q.size()), 16'(exp_q.size()), "write count");
        foreach (exp_q[i]) if (i < seen_q.size()) chk(seen_q[i], exp_q[i], "dev write");
        seen_q.delete();
        exp_q.delete();
    endtask
    task automatic setup(input tcg_row_s r);
        logic w;
        w = r.m[2];
        wr(4'h0, {10'h000, r.ck, r.m});
        wr(4'h1, r.cmp);
        rd(4'h1, st);
        chk(st, r.cmp, "compare readback");
        rd(4'h0, st);
        chk(st, {10'h000, r.ck, r.m}, "config readback");
        rd(4'h3, c0);
        if (!r.err) begin
            if (w) exp_q.push_back({8'h1a, 1'b0, r.ck, 4'h3});
            if (w) exp_q.push_back({8'h1e, r.cmp[7:0]});
            exp_q.push_back({8'h1f, w ? r.cmp[15:8] : r.cmp[7:0]});
            if (r.m == 3'h1 || r.m == 3'h6) exp_q.push_back(16'h30ff);
            exp_q.push_back(16'h3100);
            ctl = {1'b0, w ? 3'h0 : r.ck, 1'b1, r.m};
            exp_q.push_back({8'h1b, ctl});
        end
        wr(4'h2, 16'h0001);
        idle();
        chk(16'(st[2]), 16'(r.err), "error bit");
        cmpq();
    endtask
    task automatic stop();
        wr(4'h2, 16'h0002);
        idle();
        ctl = ctl & 8'hf7;
        exp_q.push_back({8'h1b, ctl});
        cmpq();
    endtask
    task automatic test_done();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge ref_clk);
        fail_count++;
        test_done();
    end
    initial begin
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rd(4'h3, st);
        chk(st, 16'h0008, "reset status");
        @(negedge ref_clk);
        chk(rdat, 16'h0000, "read data after one cycle");
        rd(4'h9, st);
        chk(st, 16'h0000, "unmapped read");
        foreach (rows[k]) begin
            setup(rows[k]);
            if (rows[k].err) begin
                wr(4'h3, 16'h0004);
                rd(4'h3, st);
                chk(16'(st[2]), 16'h0000, "error clear");
            end else begin
                repeat (400) @(posedge ref_clk);
                rd(4'h3, st);
                chk(16'(st[15:8] != c0[15:8]), 16'h0001, "irq count");
                stop();
                repeat (10) @(posedge ref_clk);
                rd(4'h3, c0);
                repeat (60) @(posedge ref_clk);
                rd(4'h3, st);
                chk(st, c0, "stopped status");
            end
        end
        // level change refused while running, then restart over a run
        setup(rows[1]);
        wr(4'h2, 16'h0004);
        idle();
        chk(16'(st[2]), 16'h0001, "level while running");
        wr(4'h3, 16'h0004);
        exp_q.push_back({8'h1b, ctl & 8'hf7});
        setup(rows[1]);
        stop();
        for (int lv = 1; lv >= 0; lv--) begin
            wr(4'h0, {9'h000, 1'(lv), 3'h3, 3'h1});
            wr(4'h2, 16'h0004);
            idle();
            ctl = {1'(lv), ctl[6:0]};
            exp_q.push_back({8'h1b, ctl});
            cmpq();
            repeat (10) @(posedge ref_clk);
            rd(4'h3, st);
            chk(16'(st[3]), 16'(lv == 0), "divider pin");
        end
        // reset in mid-run: host and device fall back, then start again cleanly
        setup(rows[0]);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rd(4'h3, st);
        chk(st, 16'h0008, "status after reset");
        setup(rows[2]);
        test_done();
    end
endmodule // tb_tcg_host

`default_nettype wire

// *** tb/tcg_dev_model.sv ***
// Purpose: behavioural timer channel 6 with channel 5 as its low half
// Assumes: one count tick per clk, or per event pin fall with clock select 111
// Notes: irq pin is stretched so the host filter can see it
`default_nettype none

module tcg_dev_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register write port
    input wire logic [7:0] dev_addr,
    input wire logic [7:0] dev_wdata,
    input wire logic dev_wr,
    // pins
    output logic irq_pin,
    output logic div_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] ctl_reg, lo_reg, hi_reg;
    logic [15:0] cnt_reg, nxt, tgt;
    logic ff_reg;
    logic [2:0] hold_reg;
    logic wide;
    logic [3:0] ev_div_reg;
    logic ev_q_reg;
    logic ev_pin;
    logic tick;
    ////////////////////////////////////////////////////////////
    always_comb begin
        wide = ctl_reg[2];
        nxt = wide ? cnt_reg + 16'h0001 : {8'h00, cnt_reg[7:0] + 8'h01};
        tgt = wide ? {hi_reg, lo_reg} : {8'h00, hi_reg};
        // event pin at clk/16, eight cycles per phase, low after reset
        ev_pin = ev_div_reg[3];
        tick = (ctl_reg[6:4] != 3'h7) || (ev_q_reg && !ev_pin);
    end
    always @(posedge clk) begin
        if (!rst_n) begin
            ctl_reg <= 8'h00;
            lo_reg <= 8'hff;
            hi_reg <= 8'hff;
            cnt_reg <= 16'h0000;
            ff_reg <= 1'b0;
            hold_reg <= 3'h0;
            ev_div_reg <= 4'h0;
            ev_q_reg <= 1'b0;
        end else begin
            hold_reg <= (hold_reg != 3'h0) ? hold_reg - 3'h1 : 3'h0;
            ev_div_reg <= ev_div_reg + 4'h1;
            ev_q_reg <= ev_pin;
            if (!ctl_reg[3]) begin
                cnt_reg <= 16'h0000;
            end else if (!tick) begin
                cnt_reg <= cnt_reg;
            end else if (nxt == tgt) begin
                cnt_reg <= 16'h0000;
                hold_reg <= 3'h4;
                if (ctl_reg[2:0] == 3'h1 || ctl_reg[2:0] == 3'h6) ff_reg <= ~ff_reg;
            end else begin
                cnt_reg <= nxt;
            end
            if (dev_wr && dev_addr == 8'h1b) ctl_reg <= dev_wdata;
            // a stop write leaves the flip-flop alone so the pin holds
            if (dev_wr && dev_addr == 8'h1b && !ctl_reg[3]) ff_reg <= dev_wdata[7];
            if (dev_wr && dev_addr == 8'h1e) lo_reg <= dev_wdata;
            if (dev_wr && dev_addr == 8'h1f) hi_reg <= dev_wdata;
        end
    end
    assign irq_pin = hold_reg != 3'h0;
    assign div_pin = ~ff_reg;
endmodule // tcg_dev_model

`default_nettype wire
